// >>> rtl/ecpx_ctrl.sv
// Extended port control register, service interrupts and mode select.
// Assumes synchronous host strobes, FIFO status from the datapath.
`timescale 1ns/1ps
module ecpx_ctrl (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Host register port
	input  wire logic       ecr_wr,
	input  wire logic       ecr_rd,
	input  wire logic [7:0] ecr_wdata,
	output logic      [7:0] ecr_rdata,
	// Legacy configuration
	input  wire logic [1:0] strap_mode,
	input  wire logic       strap_cfg_lock,
	input  wire logic       port_config_one_wr,
	input  wire logic [1:0] port_config_one_mode,
	// Port control inputs
	input  wire logic       ack_irq_allow,
	input  wire logic       ack_irq_req,
	input  wire logic       dir_reverse,
	input  wire logic       fault_n,
	// DMA handshake
	input  wire logic       dma_want,
	input  wire logic       terminal_count,
	output logic            port_dma_request,
	output logic            port_dma_request_oe_n,
	// Queue status
	input  wire logic       queue_full,
	input  wire logic       queue_empty,
	input  wire logic       queue_thresh_fwd,
	input  wire logic       queue_thresh_rev,
	input  wire logic       queue_overrun,
	input  wire logic       queue_underrun,
	output logic            queue_reset,
	// Mode outputs
	output logic      [2:0] port_mode,
	output logic            legacy_active,
	output logic      [1:0] legacy_mode,
	output logic            auto_xfer,
	// Interrupt pin
	output logic            irq,
	output logic            irq_oe_n
);
	logic [2:0] mode_q;
	logic       fdis_q;
	logic       dma_q;
	logic       smask_q;
	logic       ecr_sel_q;
	logic [1:0] leg_q;
	logic       strap_done_q;
	logic       tc_pend_q;
	logic       err_pend_q;
	logic       req_pend_q;
	logic       err_q;
	logic       qrst_q;
	logic       dreq_q;
	logic       irq_q;
	logic [7:0] rdata_q;
	wire        fault_pend;

	function automatic logic is_base(input logic [2:0] m);
		is_base = (m == ecpx_pkg::ECPX_M_COMPAT)
			| (m == ecpx_pkg::ECPX_M_BIDIR);
	endfunction

	// Mode field decode
	wire [2:0] wr_mode  = ecr_wdata[ecpx_pkg::MODE_HI:ecpx_pkg::MODE_LO];
	wire       cur_base = ~ecr_sel_q | is_base(mode_q);
	wire       mode_ok  = cur_base | is_base(wr_mode);
	wire       mode_wr  = ecr_wr & mode_ok;
	wire       to_base  = mode_wr & is_base(wr_mode);
	wire       from_ext = to_base & ecr_sel_q
		& (mode_q == ecpx_pkg::ECPX_M_EXT);
	wire       eff_auto = ecr_sel_q & ((mode_q == ecpx_pkg::ECPX_M_CFIFO)
		| (mode_q == ecpx_pkg::ECPX_M_EXT));
	wire       eff_ext  = ecr_sel_q & (mode_q == ecpx_pkg::ECPX_M_EXT);
	wire       irq_mode = ecr_sel_q & ((mode_q == ecpx_pkg::ECPX_M_CFIFO)
		| (mode_q == ecpx_pkg::ECPX_M_EXT)
		| (mode_q == ecpx_pkg::ECPX_M_TEST));

	// Service events, only while the service bit is clear
	wire thresh   = dir_reverse ? queue_thresh_rev : queue_thresh_fwd;
	wire q_error  = queue_overrun | queue_underrun;
	wire tc_evt   = dma_q & terminal_count & ~smask_q;
	wire req_evt  = eff_auto & ~dma_q & thresh & ~smask_q;
	wire err_evt  = q_error & ~smask_q;
	wire svc_evt  = tc_evt | req_evt | err_evt;
	wire wr_mask1 = ecr_wr & ecr_wdata[ecpx_pkg::SMASK_BIT];
	wire wr_dma0  = ecr_wr & ~ecr_wdata[ecpx_pkg::DMA_BIT];
	wire tc_clr   = to_base | wr_dma0 | wr_mask1;
	wire err_clr  = to_base | from_ext | wr_mask1;
	wire req_clr  = ~thresh | to_base | wr_mask1;
	wire svc_pend = tc_pend_q | err_pend_q | req_pend_q;

	// Status flags come from the queue, never from a write
	wire flag_full  = err_q | queue_full;
	wire flag_empty = err_q | (queue_empty & ~queue_full);
	wire [7:0] rd_val = {mode_q, fdis_q, dma_q, smask_q,
		flag_full, flag_empty};

	wire irq_d = svc_pend | fault_pend
		| (ack_irq_allow & ack_irq_req);

	// Control register fields
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mode_q  <= ecpx_pkg::MODE_RST;
			fdis_q  <= ecpx_pkg::FDIS_RST;
			dma_q   <= ecpx_pkg::DMA_RST;
			smask_q <= ecpx_pkg::SMASK_RST;
		end else begin
			if (mode_wr) begin
				mode_q <= wr_mode;
			end
			if (ecr_wr) begin
				fdis_q <= ecr_wdata[ecpx_pkg::FDIS_BIT];
				dma_q  <= ecr_wdata[ecpx_pkg::DMA_BIT];
			end
			if (svc_evt) begin
				smask_q <= 1'b1;
			end else if (ecr_wr) begin
				smask_q <= ecr_wdata[ecpx_pkg::SMASK_BIT];
			end
		end
	end

	// Mode ownership: legacy strap/config or control register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ecr_sel_q    <= 1'b0;
			leg_q        <= ecpx_pkg::LEG_COMPAT;
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
			if (!strap_done_q) begin
				leg_q <= strap_mode;
			end else if (port_config_one_wr && !strap_cfg_lock) begin
				leg_q     <= port_config_one_mode;
				ecr_sel_q <= 1'b0;
			end
			if (ecr_wr) begin
				ecr_sel_q <= 1'b1;
			end
		end
	end

	// Pending service conditions, set wins over clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tc_pend_q  <= 1'b0;
			err_pend_q <= 1'b0;
			req_pend_q <= 1'b0;
			err_q      <= 1'b0;
		end else begin
			tc_pend_q  <= tc_evt | (tc_pend_q & ~tc_clr);
			err_pend_q <= err_evt | (err_pend_q & ~err_clr);
			req_pend_q <= req_evt | (req_pend_q & ~req_clr);
			err_q      <= q_error | (err_q & ~to_base);
		end
	end

	// Outputs held in flip-flops
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			qrst_q  <= 1'b0;
			dreq_q  <= 1'b0;
			irq_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			qrst_q <= to_base;
			dreq_q <= dma_q & dma_want;
			irq_q  <= irq_d;
			if (ecr_rd) begin
				rdata_q <= rd_val;
			end
		end
	end

	ecpx_fault_watch i_ecpx_fault_watch (
		.clk               (clk),
		.reset_n           (reset_n),
		.enable            (eff_ext),
		.fault_irq_disable (fdis_q),
		.clear             (ecr_rd),
		.fault_n           (fault_n),
		.fault_pend        (fault_pend)
	);

	assign ecr_rdata             = rdata_q;
	assign port_dma_request      = dreq_q;
	assign port_dma_request_oe_n = ~dma_q;
	assign queue_reset           = qrst_q;
	assign port_mode             = ecr_sel_q ? mode_q : {1'b0, leg_q};
	assign legacy_active         = ~ecr_sel_q;
	assign legacy_mode           = leg_q;
	assign auto_xfer             = eff_auto;
	assign irq                   = irq_q;
	assign irq_oe_n              = ~(ack_irq_allow | irq_mode);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_tc_hit;
		dma_q && !smask_q && terminal_count;
	endsequence
	sequence s_svc_seen;
		smask_q && tc_pend_q ##1 irq;
	endsequence
	property p_tc_irq;
		s_tc_hit |=> s_svc_seen;
	endproperty
	a_tc_irq: assert property (p_tc_irq)
		else $error("Terminal count did not raise service interrupt");

	property p_tc_clear;
		ecr_wr && !ecr_wdata[3] && !(dma_q && terminal_count && !smask_q)
			|=> !tc_pend_q;
	endproperty
	a_tc_clear: assert property (p_tc_clear)
		else $error("DMA off did not clear count interrupt");

	property p_dreq_tri;
		!dma_q |-> port_dma_request_oe_n ##1 !port_dma_request;
	endproperty
	a_dreq_tri: assert property (p_dreq_tri)
		else $error("DMA request driven while DMA off");

	property p_err_flags;
		q_error |=> flag_full && flag_empty;
	endproperty
	a_err_flags: assert property (p_err_flags)
		else $error("Overrun did not set both flags");

	property p_err_svc;
		q_error && !smask_q |=> smask_q && err_pend_q ##1 irq;
	endproperty
	a_err_svc: assert property (p_err_svc)
		else $error("Queue error gave no service interrupt");

	property p_irq_pin;
		irq_oe_n == !(ack_irq_allow || (!legacy_active
			&& port_mode inside {3'h2, 3'h3, 3'h6}));
	endproperty
	a_irq_pin: assert property (p_irq_pin)
		else $error("Interrupt pin enable wrong");

	property p_mode_guard;
		ecr_wr && ecr_sel_q && !is_base(mode_q) && !is_base(wr_mode)
			|=> $stable(mode_q);
	endproperty
	a_mode_guard: assert property (p_mode_guard)
		else $error("Illegal mode change accepted");

	property p_base_reset;
		to_base && !q_error |=> queue_reset && !err_q
			##1 (queue_reset == $past(to_base));
	endproperty
	a_base_reset: assert property (p_base_reset)
		else $error("Base mode did not reset queue");

	property p_empty_flag;
		ecr_rd && !err_q && queue_empty && !queue_full
			|=> ecr_rdata[1:0] == 2'h1;
	endproperty
	a_empty_flag: assert property (p_empty_flag)
		else $error("Empty flag wrong");

	property p_full_flag;
		ecr_rd && !err_q && queue_full |=> ecr_rdata[1:0] == 2'h2;
	endproperty
	a_full_flag: assert property (p_full_flag)
		else $error("Full flag wrong");

	property p_fault_irq;
		fault_pend |=> irq;
	endproperty
	a_fault_irq: assert property (p_fault_irq)
		else $error("Fault interrupt did not reach pin");

	property p_ext_entry;
		!ecr_sel_q && !ecr_wr |=> !ecr_sel_q;
	endproperty
	a_ext_entry: assert property (p_ext_entry)
		else $error("Control register took mode without a write");

	property p_auto_start;
		mode_wr && (wr_mode == 3'h2 || wr_mode == 3'h3) |=> auto_xfer;
	endproperty
	a_auto_start: assert property (p_auto_start)
		else $error("Automatic transfer did not start");
endmodule

// >>> rtl/ecpx_pkg.sv
// Constants for the extended port control block.
// Assumes a single 40 MHz clock and an 8-bit host register port.
package ecpx_pkg;
	// Extended port control field positions
	localparam int MODE_HI    = 7;
	localparam int MODE_LO    = 5;
	localparam int FDIS_BIT   = 4;
	localparam int DMA_BIT    = 3;
	localparam int SMASK_BIT  = 2;
	localparam int FULL_BIT   = 1;
	localparam int EMPTY_BIT  = 0;
	// Values after reset
	localparam logic [2:0] MODE_RST  = 3'h0;
	localparam logic       FDIS_RST  = 1'b1;
	localparam logic       DMA_RST   = 1'b0;
	localparam logic       SMASK_RST = 1'b1;
	// Legacy modes chosen by strap or configuration
	localparam logic [1:0] LEG_COMPAT = 2'h0;
	localparam logic [1:0] LEG_BIDIR  = 2'h1;
	localparam logic [1:0] LEG_EPP    = 2'h2;
	// Extended port control modes
	typedef enum logic [2:0] {
		ECPX_M_COMPAT  = 3'b000,
		ECPX_M_BIDIR   = 3'b001,
		ECPX_M_CFIFO   = 3'b010,
		ECPX_M_EXT     = 3'b011,
		ECPX_M_RSV4    = 3'b100,
		ECPX_M_RSV5    = 3'b101,
		ECPX_M_TEST    = 3'b110,
		ECPX_M_CONFIG  = 3'b111
	} ecpx_mode_t;
endpackage

// >>> rtl/ecpx_fault_watch.sv
// Fault interrupt source of the extended port control block.
// Assumes fault_n is synchronous to clk and active low.
`timescale 1ns/1ps
module ecpx_fault_watch (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Control
	input  wire logic enable,
	input  wire logic fault_irq_disable,
	input  wire logic clear,
	// Peripheral fault line
	input  wire logic fault_n,
	// Result
	output logic      fault_pend
);
	logic fault_n_q;
	logic fdis_q;
	logic pend_q;
	wire  fall_evt;
	wire  unmask_evt;
	wire  raise;

	assign fall_evt   = fault_n_q & ~fault_n;
	assign unmask_evt = fdis_q & ~fault_irq_disable & ~fault_n;
	// Edge or unmask while asserted, only when allowed
	assign raise      = enable & ~fault_irq_disable
		& (fall_evt | unmask_evt);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fault_n_q <= 1'b1;
			fdis_q    <= 1'b1;
			pend_q    <= 1'b0;
		end else begin
			fault_n_q <= fault_n;
			fdis_q    <= fault_irq_disable;
			pend_q    <= raise | (pend_q & ~clear);
		end
	end

	assign fault_pend = pend_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_fault_edge;
		enable && !fault_irq_disable && $fell(fault_n) |=> fault_pend;
	endproperty
	a_fault_edge: assert property (p_fault_edge)
		else $error("Fault edge did not raise interrupt");

	property p_fault_unmask;
		enable && $fell(fault_irq_disable) && !fault_n |=> fault_pend;
	endproperty
	a_fault_unmask: assert property (p_fault_unmask)
		else $error("Unmask with fault asserted gave no interrupt");

	property p_fault_masked;
		fault_irq_disable && !fault_pend |=> !fault_pend;
	endproperty
	a_fault_masked: assert property (p_fault_masked)
		else $error("Fault interrupt raised while disabled");
endmodule

// >>> dv/ecpx_host_model.sv
// Host DMA controller model for the extended port control block.
// Assumes request and enable are sampled on the rising clock edge.
`timescale 1ns/1ps
module ecpx_host_model #(
	parameter int TC_AFTER = 4
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// DMA handshake
	input  wire logic port_dma_request,
	input  wire logic port_dma_request_oe_n,
	output logic      terminal_count
);
	int grants;
	// Serve requests only while the pin is driven, end the block with a count
	always @(posedge clk) begin
		if (!reset_n) begin
			grants <= 0;
			terminal_count <= 1'b0;
		end else begin
			terminal_count <= 1'b0;
			if (port_dma_request === 1'b1 && port_dma_request_oe_n === 1'b0) begin
				grants <= grants + 1;
				if (grants + 1 == TC_AFTER) begin
					terminal_count <= 1'b1;
				end
			end
		end
	end
endmodule

// >>> dv/ecpx_ctrl_tb_top.sv
// Self-checking bench for the extended port control block.
// Assumes the host model answers DMA requests with a terminal count.
`timescale 1ns/1ps
module ecpx_ctrl_tb_top;
	logic clk = 1'b0, reset_n = 1'b0, ecr_wr = 1'b0, ecr_rd = 1'b0;
	logic [7:0] ecr_wdata = 8'h00, ecr_rdata, rv;
	logic [1:0] strap_mode = 2'h1, port_config_one_mode = 2'h0, legacy_mode;
	logic strap_cfg_lock = 1'b0, port_config_one_wr = 1'b0;
	logic ack_irq_allow = 1'b0, ack_irq_req = 1'b0, dir_reverse = 1'b0;
	logic fault_n = 1'b1, dma_want = 1'b0, terminal_count;
	logic port_dma_request, port_dma_request_oe_n, queue_reset;
	logic queue_full = 1'b0, queue_empty = 1'b1, queue_underrun = 1'b0;
	logic queue_thresh_fwd = 1'b0, queue_thresh_rev = 1'b0;
	logic queue_overrun = 1'b0, legacy_active, auto_xfer, irq, irq_oe_n;
	logic [2:0] port_mode;
	int errors = 0, samples_checked = 0, resets_seen = 0;

	ecpx_ctrl i_ecpx_ctrl (.clk(clk), .reset_n(reset_n), .ecr_wr(ecr_wr),
		.ecr_rd(ecr_rd), .ecr_wdata(ecr_wdata), .ecr_rdata(ecr_rdata),
		.strap_mode(strap_mode), .strap_cfg_lock(strap_cfg_lock),
		.port_config_one_wr(port_config_one_wr),
		.port_config_one_mode(port_config_one_mode),
		.ack_irq_allow(ack_irq_allow), .ack_irq_req(ack_irq_req),
		.dir_reverse(dir_reverse), .fault_n(fault_n), .dma_want(dma_want),
		.terminal_count(terminal_count), .port_dma_request(port_dma_request),
		.port_dma_request_oe_n(port_dma_request_oe_n),
		.queue_full(queue_full), .queue_empty(queue_empty),
		.queue_thresh_fwd(queue_thresh_fwd),
		.queue_thresh_rev(queue_thresh_rev), .queue_overrun(queue_overrun),
		.queue_underrun(queue_underrun), .queue_reset(queue_reset),
		.port_mode(port_mode), .legacy_active(legacy_active),
		.legacy_mode(legacy_mode), .auto_xfer(auto_xfer), .irq(irq),
		.irq_oe_n(irq_oe_n));
	ecpx_host_model i_ecpx_host_model (.clk(clk), .reset_n(reset_n),
		.port_dma_request(port_dma_request),
		.port_dma_request_oe_n(port_dma_request_oe_n),
		.terminal_count(terminal_count));

	initial begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (queue_reset === 1'b1) resets_seen++;
	end

	task automatic chk(input string nm, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge clk) ecr_wr = 1'b1;
		ecr_wdata = d;
		@(negedge clk) ecr_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(output logic [7:0] d);
		@(negedge clk) ecr_rd = 1'b1;
		@(negedge clk) ecr_rd = 1'b0;
		@(negedge clk) d = ecr_rdata;
	endtask
	task automatic irq_is(input logic e);
		for (int i = 0; i < 10 && irq !== e; i++) @(negedge clk);
		chk("irq", {7'h0, irq}, {7'h0, e});
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic t_reset();
		rd(rv);
		chk("control", rv, 8'h15);
		chk("irq_oe_n", {7'h0, irq_oe_n}, 8'h01);
		chk("dreq_oe_n", {7'h0, port_dma_request_oe_n}, 8'h01);
		chk("mode", {5'h0, port_mode}, 8'h01);
		chk("legacy_mode", {6'h0, legacy_mode}, 8'h01);
		$display("test reset done");
	endtask
	task automatic t_mode_dma();
		wr(8'h68);
		chk("mode", {5'h0, port_mode}, 8'h03);
		chk("auto", {7'h0, auto_xfer}, 8'h01);
		chk("irq_oe_n", {7'h0, irq_oe_n}, 8'h00);
		chk("dreq_oe_n", {7'h0, port_dma_request_oe_n}, 8'h00);
		wr(8'hcb);
		chk("mode", {5'h0, port_mode}, 8'h03);
		queue_full = 1'b1;
		queue_empty = 1'b0;
		rd(rv);
		chk("control", rv, 8'h6a);
		queue_full = 1'b0;
		queue_empty = 1'b1;
		dma_want = 1'b1;
		irq_is(1'b1);
		chk("dreq", {7'h0, port_dma_request}, 8'h01);
		dma_want = 1'b0;
		rd(rv);
		chk("control", rv, 8'h6d);
		wr(8'h60);
		irq_is(1'b0);
		$display("test mode and dma done");
	endtask
	task automatic t_error();
		@(negedge clk) queue_overrun = 1'b1;
		@(negedge clk) queue_overrun = 1'b0;
		irq_is(1'b1);
		rd(rv);
		chk("control", rv, 8'h67);
		wr(8'h14);
		irq_is(1'b0);
		chk("queue resets", resets_seen[7:0], 8'h01);
		rd(rv);
		chk("control", rv, 8'h15);
		wr(8'h10);
		@(negedge clk) queue_underrun = 1'b1;
		@(negedge clk) queue_underrun = 1'b0;
		irq_is(1'b1);
		rd(rv);
		chk("control", rv, 8'h17);
		wr(8'h14);
		irq_is(1'b0);
		$display("test error done");
	endtask
	task automatic t_thresh();
		queue_thresh_fwd = 1'b1;
		wr(8'h40);
		irq_is(1'b1);
		wr(8'h44);
		irq_is(1'b0);
		queue_thresh_fwd = 1'b0;
		wr(8'h14);
		dir_reverse = 1'b1;
		queue_thresh_rev = 1'b1;
		wr(8'h40);
		irq_is(1'b1);
		wr(8'h14);
		queue_thresh_rev = 1'b0;
		dir_reverse = 1'b0;
		$display("test threshold done");
	endtask
	task automatic t_fault();
		wr(8'h64);
		@(negedge clk) fault_n = 1'b0;
		irq_is(1'b1);
		rd(rv);
		irq_is(1'b0);
		fault_n = 1'b1;
		wr(8'h74);
		@(negedge clk) fault_n = 1'b0;
		repeat (4) @(negedge clk);
		chk("irq", {7'h0, irq}, 8'h00);
		wr(8'h64);
		irq_is(1'b1);
		rd(rv);
		fault_n = 1'b1;
		wr(8'h14);
		ack_irq_allow = 1'b1;
		ack_irq_req = 1'b1;
		irq_is(1'b1);
		chk("irq_oe_n", {7'h0, irq_oe_n}, 8'h00);
		ack_irq_req = 1'b0;
		ack_irq_allow = 1'b0;
		$display("test fault done");
	endtask
	task automatic t_legacy();
		@(negedge clk) port_config_one_mode = 2'h2;
		port_config_one_wr = 1'b1;
		@(negedge clk) port_config_one_wr = 1'b0;
		@(negedge clk);
		chk("legacy", {6'h0, legacy_active, auto_xfer}, 8'h02);
		chk("mode", {5'h0, port_mode}, 8'h02);
		chk("legacy_mode", {6'h0, legacy_mode}, 8'h02);
		strap_cfg_lock = 1'b1;
		@(negedge clk) port_config_one_mode = 2'h1;
		port_config_one_wr = 1'b1;
		@(negedge clk) port_config_one_wr = 1'b0;
		@(negedge clk);
		chk("mode", {5'h0, port_mode}, 8'h02);
		wr(8'h20);
		chk("legacy", {7'h0, legacy_active}, 8'h00);
		chk("mode", {5'h0, port_mode}, 8'h01);
		$display("test legacy done");
	endtask

	initial begin
		repeat (20) @(negedge clk);
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		t_reset();
		t_mode_dma();
		t_error();
		t_thresh();
		t_fault();
		t_legacy();
		close_out();
	end
	initial begin
		#(25 * 5000);
		errors++;
		close_out();
	end
endmodule
